/* File: rtl/hsm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hsm_cfg.svh"
module hsm_monitor
	import hsm_pkg::*;
#(
	parameter int NCH = 2,
	parameter int SAMPLE_CYC = `HSM_SAMPLE_CYC
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [NCH-1:0][1:0] sense_range_pin,
	input wire logic [1:0] protect_level_pin,
	input wire logic [NCH-1:0] range_wr,
	input wire logic [NCH-1:0][1:0] range_wdata,
	input wire logic [NCH-1:0] dac_wr,
	input wire logic [NCH-1:0][7:0] dac_wdata,
	input wire logic ratio_wr,
	input wire logic [NCH-1:0][1:0] ratio_wdata,
	input wire logic vfs_wr,
	input wire logic [NCH-1:0][1:0] vfs_wdata,
	input wire logic [NCH-1:0] lim_wr,
	input wire hsm_lim_t [NCH-1:0] lim_wdata,
	input wire logic [NCH-1:0] peak_clear_ctrl,
	input wire logic [NCH-1:0] chan_startup,
	input wire logic [NCH-1:0] fast_trip_cmp,
	input wire logic [NCH-1:0] slow_trip_cmp,
	input wire logic [NCH-1:0][9:0] adc_i,
	input wire logic [NCH-1:0][9:0] adc_v,
	input wire logic adc_valid,
	output logic [NCH-1:0][1:0] range_status_reg,
	output logic [NCH-1:0][1:0] fast_slow_ratio_sel,
	output logic [NCH-1:0][1:0] voltage_fullscale_sel,
	output logic [NCH-1:0][9:0] fast_trip_mv10,
	output logic [NCH-1:0][9:0] slow_trip_mv10,
	output hsm_split_t [NCH-1:0] current_result,
	output hsm_split_t [NCH-1:0] voltage_result,
	output hsm_split_t [NCH-1:0] current_min,
	output hsm_split_t [NCH-1:0] current_max,
	output logic [NCH-1:0] fault_out,
	output logic [NCH-1:0] power_good_out,
	output logic [NCH-1:0] shutdown_out,
	output logic alert_out,
	output logic adc_start
);
	logic [NCH-1:0][1:0] rng_s1_r, rng_s2_r;
	logic [1:0] prot_s1_r, prot_s2_r;
	logic [1:0] strap_cnt_r;
	logic [NCH-1:0][7:0] dac_r;
	hsm_lim_t [NCH-1:0] lim_r;
	logic [15:0] div_r;
	logic sample_tick;
	hsm_state_t state_r, state_nxt;
	logic [NCH-1:0][9:0] cur_r, vol_r, cmin, cmax;
	logic [NCH-1:0] crit_c, warn_c, oc_c;
	logic [NCH-1:0] alert_ch_r;

	// Full-scale range in tenths of a millivolt
	function automatic logic [9:0] fs_tenth_mv(input logic [1:0] rng);
		case (rng)
			HSM_RNG_25MV: fs_tenth_mv = 10'd250;
			HSM_RNG_50MV: fs_tenth_mv = 10'd500;
			default: fs_tenth_mv = 10'd1000;
		endcase
	endfunction

	// Fast-trip = fs * (40% + 60% * code/255)
	function automatic logic [9:0] fast_thr(input logic [1:0] rng, input logic [7:0] code);
		logic [31:0] fs;
		logic [31:0] t;
		fs = {22'h0, fs_tenth_mv(rng)};
		t = (fs * `HSM_FT_BASE_PCT) / 100 + (fs * `HSM_FT_SPAN_PCT * {24'h0, code}) / (100 * 255);
		fast_thr = t[9:0];
	endfunction

	// Slow-trip = fast / ratio; ratio in percent
	function automatic logic [9:0] slow_thr(input logic [9:0] ft, input logic [1:0] sel);
		logic [31:0] r;
		logic [31:0] t;
		case (sel)
			2'h0: r = 32'd200;
			2'h1: r = 32'd175;
			2'h2: r = 32'd150;
			default: r = 32'd125;
		endcase
		t = ({22'h0, ft} * 100) / r;
		slow_thr = t[9:0];
	endfunction

	function automatic hsm_split_t split10(input logic [9:0] v);
		split10.hi = v[9:2];
		split10.lo = v[1:0];
	endfunction

	// Pins come from outside the clock domain
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rng_s1_r <= '0;
			rng_s2_r <= '0;
			prot_s1_r <= 2'h0;
			prot_s2_r <= 2'h0;
		end
		else
		begin
			rng_s1_r <= sense_range_pin;
			rng_s2_r <= rng_s1_r;
			prot_s1_r <= protect_level_pin;
			prot_s2_r <= prot_s1_r;
		end
	end

	// Strap is caught once the synchroniser has filled after release
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			strap_cnt_r <= 2'h0;
		else if (strap_cnt_r != `HSM_STRAP_CYC)
			strap_cnt_r <= strap_cnt_r + 2'h1;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			range_status_reg <= '0;
		else
			for (int c = 0; c < NCH; c++)
				if (range_wr[c])
					range_status_reg[c] <= range_wdata[c];
				else if (strap_cnt_r != `HSM_STRAP_CYC)
					range_status_reg[c] <= rng_s2_r[c];
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			fast_slow_ratio_sel <= {NCH{`HSM_RATIO_RST}};
		else if (ratio_wr)
			fast_slow_ratio_sel <= ratio_wdata;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			voltage_fullscale_sel <= {NCH{`HSM_VFS_RST}};
		else if (vfs_wr)
			voltage_fullscale_sel <= vfs_wdata;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dac_r <= '0;
			lim_r <= '0;
		end
		else
			for (int c = 0; c < NCH; c++)
			begin
				if (dac_wr[c])
					dac_r[c] <= dac_wdata[c];
				if (lim_wr[c])
					lim_r[c] <= lim_wdata[c];
			end
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fast_trip_mv10 <= '0;
			slow_trip_mv10 <= '0;
		end
		else
			for (int c = 0; c < NCH; c++)
			begin
				fast_trip_mv10[c] <= fast_thr(range_status_reg[c], dac_r[c]);
				slow_trip_mv10[c] <= slow_thr(fast_thr(range_status_reg[c], dac_r[c]), fast_slow_ratio_sel[c]);
			end
	end

	// Sample-rate divider
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			div_r <= 16'h0;
		else if (div_r == 16'(SAMPLE_CYC - 1))
			div_r <= 16'h0;
		else
			div_r <= div_r + 16'h1;
	end
	assign sample_tick = div_r == 16'(SAMPLE_CYC - 1);

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			HSM_ST_IDLE: if (sample_tick) state_nxt = HSM_ST_CONV_I;
			HSM_ST_CONV_I: if (adc_valid) state_nxt = HSM_ST_CONV_V;
			HSM_ST_CONV_V: if (adc_valid) state_nxt = HSM_ST_IDLE;
			default: state_nxt = HSM_ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= HSM_ST_IDLE;
		else
			state_r <= state_nxt;
	end

	assign adc_start = state_r == HSM_ST_IDLE && sample_tick;

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur_r <= '0;
			vol_r <= '0;
		end
		else
		begin
			if (state_r == HSM_ST_CONV_I && adc_valid)
			begin
				cur_r <= adc_i;
			end
			if (state_r == HSM_ST_CONV_V && adc_valid)
				vol_r <= adc_v;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			hsm_peak #(.W(10)) u_peak (
				.mclk(mclk),
				.rst_n(rst_n),
				.clr(peak_clear_ctrl[g] | chan_startup[g]),
				.upd(state_r == HSM_ST_CONV_I && adc_valid),
				.smp(adc_i[g]),
				.min_r(cmin[g]),
				.max_r(cmax[g])
			);
			assign current_result[g] = split10(cur_r[g]);
			assign voltage_result[g] = split10(vol_r[g]);
			assign current_min[g] = split10(cmin[g]);
			assign current_max[g] = split10(cmax[g]);
		end
	endgenerate

	// Held results are compared, so a warning stands until the next sample
	always_comb
	begin
		crit_c = '0;
		warn_c = '0;
		oc_c = '0;
		for (int c = 0; c < NCH; c++)
		begin
			crit_c[c] = vol_r[c] < lim_r[c].uv_crit || vol_r[c] > lim_r[c].ov_crit;
			warn_c[c] = vol_r[c] < lim_r[c].uv_warn || vol_r[c] > lim_r[c].ov_warn;
			oc_c[c] = cur_r[c] > lim_r[c].oc_warn;
		end
	end

	// Power-good, shutdown, alert, fault
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			power_good_out <= '0;
			shutdown_out <= '0;
			alert_ch_r <= '0;
			fault_out <= '0;
		end
		else
			for (int c = 0; c < NCH; c++)
			begin
				// A trip beats the startup clear so a channel cannot restart into a fault
				if (crit_c[c] && prot_s2_r == HSM_PROT_LOW)
					shutdown_out[c] <= 1'b1;
				else if (chan_startup[c])
					shutdown_out[c] <= 1'b0;
				power_good_out[c] <= !crit_c[c] && !shutdown_out[c] &&
					!(crit_c[c] && prot_s2_r != HSM_PROT_OPEN);
				alert_ch_r[c] <= (power_good_out[c] && (warn_c[c] || oc_c[c])) || crit_c[c];
				if (fast_trip_cmp[c] || slow_trip_cmp[c])
					fault_out[c] <= 1'b1;
				else if (chan_startup[c])
					fault_out[c] <= 1'b0;
			end
	end

	assign alert_out = |alert_ch_r;
endmodule // hsm_monitor
`default_nettype wire

/* File: include/hsm_cfg.svh */
`ifndef HSM_CFG_SVH
`define HSM_CFG_SVH
`define HSM_RATIO_RST 2'h0
`define HSM_VFS_RST 2'h0
`define HSM_MIN_RST 10'h3ff
`define HSM_MAX_RST 10'h000
`define HSM_STRAP_CYC 2'h3
`define HSM_CLK_MHZ 125
`define HSM_SPS 10000
`define HSM_SAMPLE_CYC ((`HSM_CLK_MHZ * 1000000) / `HSM_SPS)
`define HSM_FT_BASE_PCT 40
`define HSM_FT_SPAN_PCT 60
`endif

/* File: include/hsm_pkg.sv */
package hsm_pkg;
	typedef enum logic [1:0] {
		HSM_RNG_25MV = 2'b00,
		HSM_RNG_50MV = 2'b01,
		HSM_RNG_100MV = 2'b10
	} hsm_range_t;
	typedef enum logic [1:0] {
		HSM_PROT_LOW = 2'b00,
		HSM_PROT_HIGH = 2'b01,
		HSM_PROT_OPEN = 2'b10
	} hsm_prot_t;
	typedef struct packed {
		logic [9:0] uv_warn;
		logic [9:0] uv_crit;
		logic [9:0] ov_warn;
		logic [9:0] ov_crit;
		logic [9:0] oc_warn;
	} hsm_lim_t;
	typedef struct packed {
		logic [7:0] hi;
		logic [1:0] lo;
	} hsm_split_t;
	typedef enum logic [1:0] {
		HSM_ST_IDLE = 2'b00,
		HSM_ST_CONV_I = 2'b01,
		HSM_ST_CONV_V = 2'b10
	} hsm_state_t;
endpackage

/* File: rtl/hsm_peak.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hsm_cfg.svh"
module hsm_peak
	import hsm_pkg::*;
#(
	parameter int W = 10
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic upd,
	input wire logic [W-1:0] smp,
	output logic [W-1:0] min_r,
	output logic [W-1:0] max_r
);
	// Clear has priority so a held startup restarts tracking cleanly
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			min_r <= `HSM_MIN_RST;
		else if (clr)
			min_r <= `HSM_MIN_RST;
		else if (upd && smp < min_r)
			min_r <= smp;
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			max_r <= `HSM_MAX_RST;
		else if (clr)
			max_r <= `HSM_MAX_RST;
		else if (upd && smp > max_r)
			max_r <= smp;
	end
endmodule // hsm_peak
`default_nettype wire

/* File: testbench/hsm_monitor_props.sv */
`timescale 1ns/1ps
`default_nettype none
module hsm_monitor_props
	import hsm_pkg::*;
#(
	parameter int NCH = 2
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [NCH-1:0] peak_clear_ctrl,
	input wire logic [NCH-1:0] chan_startup,
	input wire logic [NCH-1:0] fast_trip_cmp,
	input wire logic [NCH-1:0] slow_trip_cmp,
	input wire logic [NCH-1:0][1:0] fast_slow_ratio_sel,
	input wire logic [NCH-1:0][1:0] voltage_fullscale_sel,
	input wire hsm_split_t [NCH-1:0] current_result,
	input wire hsm_split_t [NCH-1:0] current_min,
	input wire hsm_split_t [NCH-1:0] current_max,
	input wire logic [NCH-1:0] fault_out
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_ratio_rst: assert property ($rose(rst_n) |-> fast_slow_ratio_sel == '0)
		else $error("ratio reset");
	a_vfs_rst: assert property ($rose(rst_n) |-> voltage_fullscale_sel == '0)
		else $error("full scale reset");
	a_peak_rst: assert property ($rose(rst_n) |-> current_min[0] == 10'h3ff && current_max[0] == 10'h000)
		else $error("peak reset");
	a_startup_clr: assert property (chan_startup[0] |=> current_min[0] == 10'h3ff && current_max[0] == 10'h000)
		else $error("startup clear");
	a_peak_clr: assert property (peak_clear_ctrl[0] |=> current_min[0] == 10'h3ff && current_max[0] == 10'h000)
		else $error("soft clear");
	a_peak_track: assert property ($changed(current_result[0]) && !$past(peak_clear_ctrl[0]) && !$past(chan_startup[0])
		|-> current_max[0] >= current_result[0] && current_min[0] <= current_result[0]) else $error("peak track");
	a_fault_trip: assert property (fast_trip_cmp[0] || slow_trip_cmp[0] |-> ##[1:3] fault_out[0])
		else $error("no fault");
	a_fault_hold: assert property (fault_out[0] && !chan_startup[0] |=> fault_out[0])
		else $error("fault dropped");
	c_startup: cover property (chan_startup[0] ##1 current_min[0] == 10'h3ff);
	c_fault: cover property ($rose(fault_out[0]));
	c_track: cover property ($changed(current_max[0]));
endmodule // hsm_monitor_props
bind hsm_monitor hsm_monitor_props #(.NCH(NCH)) u_props (.mclk, .rst_n, .peak_clear_ctrl, .chan_startup,
	.fast_trip_cmp, .slow_trip_cmp, .fast_slow_ratio_sel, .voltage_fullscale_sel, .current_result,
	.current_min, .current_max, .fault_out);
`default_nettype wire

/* File: testbench/hsm_adc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hsm_adc_model
	import hsm_pkg::*;
#(
	parameter int NCH = 2
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic adc_start,
	input wire logic [NCH-1:0][9:0] cur,
	input wire logic [NCH-1:0][9:0] vol,
	output logic [NCH-1:0][9:0] adc_i,
	output logic [NCH-1:0][9:0] adc_v,
	output logic adc_valid,
	output logic done
);
	logic [2:0] cnt_r;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= 3'h0;
		else if (adc_start || cnt_r != 3'h0)
			cnt_r <= adc_start ? 3'h1 : cnt_r + 3'h1;
	end
	// Current first, voltage second; data lines show inverted values between strobes
	assign adc_valid = cnt_r == 3'h2 || cnt_r == 3'h4;
	assign adc_i = cnt_r == 3'h2 ? cur : ~cur;
	assign adc_v = cnt_r == 3'h4 ? vol : ~vol;
	assign done = cnt_r == 3'h7;
endmodule // hsm_adc_model
`default_nettype wire

/* File: testbench/tb_hsm_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_hsm_monitor
	import hsm_pkg::*;
;
	logic mclk = 1'b0, rst_n = 1'b0, ratio_wr = 1'b0, vfs_wr = 1'b0, adc_valid, alert_out, adc_start, done;
	logic [1:0] protect_level_pin = 2'h0, range_wr = '0, dac_wr = '0, lim_wr = '0, peak_clear_ctrl = '0;
	logic [1:0] chan_startup = '0, fast_trip_cmp = '0, slow_trip_cmp = '0, fault_out, power_good_out, shutdown_out;
	logic [1:0][1:0] sense_range_pin = 4'h6, range_wdata = '0, ratio_wdata = '0, vfs_wdata = '0;
	logic [1:0][1:0] range_status_reg, fast_slow_ratio_sel, voltage_fullscale_sel;
	logic [1:0][7:0] dac_wdata = 16'hff00;
	logic [1:0][9:0] adc_i, adc_v, cur = '0, vol = '0, fast_trip_mv10, slow_trip_mv10;
	hsm_lim_t [1:0] lim_wdata = {2{10'h0c8, 10'h064, 10'h320, 10'h384, 10'h1f4}};
	hsm_split_t [1:0] current_result, voltage_result, current_min, current_max;
	int n_mismatch = 0, samples_checked = 0;
	always #4 mclk = ~mclk;
	hsm_monitor #(.NCH(2), .SAMPLE_CYC(20)) dut_u (.mclk, .rst_n, .sense_range_pin, .protect_level_pin, .range_wr,
		.range_wdata, .dac_wr, .dac_wdata, .ratio_wr, .ratio_wdata, .vfs_wr, .vfs_wdata, .lim_wr, .lim_wdata,
		.peak_clear_ctrl, .chan_startup, .fast_trip_cmp, .slow_trip_cmp, .adc_i, .adc_v, .adc_valid,
		.range_status_reg, .fast_slow_ratio_sel, .voltage_fullscale_sel, .fast_trip_mv10, .slow_trip_mv10,
		.current_result, .voltage_result, .current_min, .current_max, .fault_out, .power_good_out,
		.shutdown_out, .alert_out, .adc_start);
	hsm_adc_model #(.NCH(2)) adc_u (.mclk, .rst_n, .adc_start, .cur, .vol, .adc_i, .adc_v, .adc_valid, .done);
	task automatic tk(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic chk(input logic [9:0] got, input logic [9:0] exp, input int tol = 0);
		samples_checked++;
		if ((^got === 1'bx) || (got > exp + tol) || (got + tol < exp))
		begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Two full conversions, so a round already under way with old data never counts
	task automatic smp(input logic [9:0] c, input logic [9:0] v);
		int k, d;
		cur = {c, c};
		vol = {v, v};
		k = 0;
		d = 0;
		while (d < 2 && k++ < 200)
		begin
			tk(1);
			d += done;
		end
		n_mismatch += (d < 2);
		if (d < 2)
			close_out();
		tk(3);
	endtask
	task automatic restart;
		chan_startup = 2'h3;
		tk(2);
		chk(current_min[0], 10'h3ff);
		chk(current_max[1], 10'h000);
		chan_startup = 2'h0;
	endtask
	initial
	begin
		tk(10);
		rst_n = 1'b1;
		tk(3);
		chk(fast_slow_ratio_sel, 10'h0);
		chk(voltage_fullscale_sel, 10'h0);
		chk(current_min[1], 10'h3ff);
		chk(current_max[0], 10'h000);
		chk(range_status_reg, 10'h006);
		for (int r = 0; r < 3; r++)
		begin
			range_wdata = {2'(r), 2'(r)};
			range_wr = 2'h3;
			dac_wr = 2'h3;
			tk(1);
			range_wr = 2'h0;
			dac_wr = 2'h0;
			tk(3);
			chk(range_status_reg[0], 10'(r));
			chk(fast_trip_mv10[1], 10'h0fa << r);
			chk(fast_trip_mv10[0], 10'h064 << r);
		end
		for (int q = 0; q < 4; q++)
		begin
			ratio_wdata = {2'(q), 2'(q)};
			vfs_wdata = ratio_wdata;
			ratio_wr = 1'b1;
			vfs_wr = 1'b1;
			tk(1);
			ratio_wr = 1'b0;
			vfs_wr = 1'b0;
			tk(3);
			chk(slow_trip_mv10[1], 10'(4000 / (8 - q)), 1);
			chk(voltage_fullscale_sel[0], 10'(q));
		end
		lim_wr = 2'h3;
		tk(1);
		lim_wr = 2'h0;
		for (int p = 0; p < 3; p++)
		begin
			protect_level_pin = 2'(p);
			// Voltage back in range first, so the restart is not undone by a stale critical sample
			smp(10'h12c, 10'h1f4);
			restart();
			smp(10'h12c, 10'h1f4);
			chk(power_good_out, 10'h3);
			chk(alert_out, 10'h0);
			smp(10'h3f1, 10'h1f4);
			chk(alert_out, 10'h1);
			chk(current_result[1].hi, 10'h0fc);
			chk(current_result[1], 10'h3f1);
		end
		chk(current_max[0], 10'h3f1);
		chk(current_min[0], 10'h12c);
		peak_clear_ctrl = 2'h3;
		tk(2);
		chk(current_max[0], 10'h000);
		peak_clear_ctrl = 2'h0;
		smp(10'h12c, 10'h352);
		chk(alert_out, 10'h1);
		chk(voltage_result[1], 10'h352);
		chk(current_max[1], 10'h12c);
		for (int p = 0; p < 3; p++)
		begin
			protect_level_pin = 2'(p);
			// A critical sample beats the startup clear, so the new protect level settles first
			tk(3);
			restart();
			smp(10'h12c, 10'h3e8);
			chk(power_good_out, 10'h0);
			chk(shutdown_out, (p == 0) ? 10'h3 : 10'h0);
			chk(alert_out, 10'h1);
		end
		fast_trip_cmp = 2'h2;
		tk(1);
		fast_trip_cmp = 2'h0;
		slow_trip_cmp = 2'h1;
		tk(1);
		slow_trip_cmp = 2'h0;
		tk(3);
		chk(fault_out, 10'h3);
		restart();
		chk(fault_out, 10'h0);
		close_out();
	end
endmodule // tb_hsm_monitor
`default_nettype wire
